// file: digital_input_image_packer.sv
// Packs digital input module bytes into the word-aligned input image
`timescale 1ns/100ps

module digital_input_image_packer
  import dig_image_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 125 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic scan_start_i, // Pulse: build a new image
  input wire logic [dig_image_pkg::ADDR_W-1:0] analog_words_i, // Analog size
  input wire logic [dig_image_pkg::NUM_SLOTS*dig_image_pkg::KIND_W-1:0]
    slot_kind_i, // Kind per slot
  input wire logic [dig_image_pkg::NUM_SLOTS*dig_image_pkg::CH_MAX-1:0]
    slot_state_i, // Channel levels per slot
  input wire logic [dig_image_pkg::NUM_SLOTS*dig_image_pkg::CH_MAX-1:0]
    slot_fault_i, // Channel faults per slot
  output logic img_wr_o, // Pulse: image word write
  output logic [dig_image_pkg::ADDR_W-1:0] img_addr_o, // Image word address
  output logic [dig_image_pkg::WORD_W-1:0] img_data_o, // Image word data
  output logic busy_o, // Scan in progress
  output logic done_o // Pulse: scan finished
);
  import dig_image_pkg::*;

  localparam int SCAN_MAX_CYC = NUM_SLOTS + 2;

  pack_state_type state_r, state_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic half_r, half_nxt;
  logic flush_r, flush_nxt;
  logic [ADDR_W-1:0] word_r, word_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [BYTE_W-1:0] lo_r, lo_nxt;
  logic [NUM_SLOTS*KIND_W-1:0] kind_r, kind_nxt;
  logic [NUM_SLOTS*CH_MAX-1:0] lvl_r, lvl_nxt;
  logic [NUM_SLOTS*CH_MAX-1:0] flt_r, flt_nxt;
  logic img_wr_nxt, busy_nxt, done_nxt;
  logic [ADDR_W-1:0] img_addr_nxt, next_addr;
  logic [WORD_W-1:0] img_data_nxt;
  logic [BYTE_W-1:0] slot_byte [NUM_SLOTS];
  slot_kind_type slot_kind [NUM_SLOTS];
  logic [BYTE_W-1:0] cur_byte;
  slot_kind_type cur_kind;

  // One former per slot on the frozen snapshot
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    assign slot_kind[g] = slot_kind_type'(kind_r[g*KIND_W +: KIND_W]);
    digital_slot_byte_former u_former (
      .kind_i(slot_kind[g]),
      .state_i(lvl_r[g*CH_MAX +: CH_MAX]),
      .fault_i(flt_r[g*CH_MAX +: CH_MAX]),
      .byte_o(slot_byte[g])
    );
  end

  // Current slot and the address of the word being filled
  assign cur_byte = slot_byte[slot_r];
  assign cur_kind = slot_kind[slot_r];
  assign next_addr = base_r + word_r;

  // Scan sequencer; inputs are frozen at start so a word never mixes scans
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    half_nxt = half_r;
    word_nxt = word_r;
    base_nxt = base_r;
    lo_nxt = lo_r;
    kind_nxt = kind_r;
    lvl_nxt = lvl_r;
    flt_nxt = flt_r;
    img_wr_nxt = 1'b0;
    img_addr_nxt = img_addr_o;
    img_data_nxt = img_data_o;
    busy_nxt = busy_o;
    done_nxt = 1'b0;
    flush_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (scan_start_i) begin
          kind_nxt = slot_kind_i;
          lvl_nxt = slot_state_i;
          flt_nxt = slot_fault_i;
          base_nxt = analog_words_i;
          slot_nxt = SLOT_ZERO;
          half_nxt = 1'b0;
          word_nxt = ADDR_ZERO;
          busy_nxt = 1'b1;
          state_nxt = ST_PACK;
        end
      end
      ST_PACK: begin
        // Empty slots take no image space, so later bytes close up
        if (cur_kind != KIND_NONE) begin
          if (!half_r) begin
            lo_nxt = cur_byte;
            half_nxt = 1'b1;
          end else begin
            img_wr_nxt = 1'b1;
            img_addr_nxt = next_addr;
            img_data_nxt = {cur_byte, lo_r};
            word_nxt = word_r + ADDR_ONE;
            half_nxt = 1'b0;
          end
        end
        if (slot_r == LAST_SLOT) begin
          if (half_nxt) begin
            state_nxt = ST_FLUSH;
          end else begin
            state_nxt = ST_IDLE;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
          end
        end else begin
          slot_nxt = slot_r + SLOT_ONE;
        end
      end
      ST_FLUSH: begin
        // An odd last byte is padded so the image stays in whole words
        img_wr_nxt = 1'b1;
        img_addr_nxt = next_addr;
        img_data_nxt = {BYTE_ZERO, lo_r};
        flush_nxt = 1'b1;
        word_nxt = word_r + ADDR_ONE;
        half_nxt = 1'b0;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Registers only; outputs leave straight from these flops, local port only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      slot_r <= SLOT_ZERO;
      half_r <= 1'b0;
      flush_r <= 1'b0;
      word_r <= ADDR_ZERO;
      base_r <= ADDR_ZERO;
      lo_r <= BYTE_ZERO;
      kind_r <= '0;
      lvl_r <= '0;
      flt_r <= '0;
      img_wr_o <= 1'b0;
      img_addr_o <= ADDR_ZERO;
      img_data_o <= WORD_ZERO;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      half_r <= half_nxt;
      flush_r <= flush_nxt;
      word_r <= word_nxt;
      base_r <= base_nxt;
      lo_r <= lo_nxt;
      kind_r <= kind_nxt;
      lvl_r <= lvl_nxt;
      flt_r <= flt_nxt;
      img_wr_o <= img_wr_nxt;
      img_addr_o <= img_addr_nxt;
      img_data_o <= img_data_nxt;
      busy_o <= busy_nxt;
      done_o <= done_nxt;
    end
  end

  // Checks on the packing and the word stream
  sequence s_start;
    state_r == ST_IDLE && scan_start_i;
  endsequence
  sequence s_finish;
    done_o && !busy_o;
  endsequence

  a_scan_finishes:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_start |-> ##[1:SCAN_MAX_CYC] s_finish)
    else $error("Scan did not finish in time");

  a_addr_after_analog:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    img_wr_o |-> img_addr_o == $past(next_addr) && img_addr_o >= base_r)
    else $error("Image word written at wrong address");

  a_low_byte_first:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    img_wr_o && !flush_r |->
      img_data_o[LO_LSB +: BYTE_W] == $past(lo_r) &&
      img_data_o[HI_LSB +: BYTE_W] == $past(cur_byte))
    else $error("Image word byte order wrong");

  a_flush_pads_zero:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    flush_r |-> img_wr_o && img_data_o[HI_LSB +: BYTE_W] == BYTE_ZERO)
    else $error("Odd last byte not padded with zero");

  a_write_only_busy:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    img_wr_o |-> $past(busy_o) && $past(state_r) != ST_IDLE)
    else $error("Image written outside a scan");

  a_single_diag_layout:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    slot_kind[0] == KIND_1CH_DIAG |->
      slot_byte[0] == {6'h00, flt_r[0], lvl_r[0]})
    else $error("Single channel diagnostic byte wrong");

  a_two_plain_layout:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    slot_kind[0] == KIND_2CH |-> slot_byte[0] == {6'h00, lvl_r[1:0]})
    else $error("Two channel byte wrong");

  a_two_diag_layout:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    slot_kind[0] == KIND_2CH_DIAG |->
      slot_byte[0] == {4'h0, flt_r[1:0], lvl_r[1:0]})
    else $error("Two channel diagnostic byte wrong");

  a_fault_bit_follows:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    slot_kind[1] == KIND_2CH_DIAG |->
      slot_byte[1][FAULT_CH1_POS] == flt_r[CH_MAX])
    else $error("Fault bit does not follow the channel");

  a_level_bits_wide:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    slot_kind[0] == KIND_4CH |-> slot_byte[0] == {4'h0, lvl_r[3:0]})
    else $error("Four channel level bits wrong");

  a_empty_slot_zero:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    slot_kind[0] == KIND_NONE |-> slot_byte[0] == BYTE_ZERO)
    else $error("Empty slot byte not zero");
endmodule : digital_input_image_packer

// file: dig_image_pkg.sv
// Shared constants and types for the digital input image packer
package dig_image_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int NUM_SLOTS = 4;
  localparam int SLOT_W = 2;
  localparam int KIND_W = 3;
  localparam int ADDR_W = 8;
  localparam int CH_MAX = 8;
  // Bit positions within a module's image byte
  localparam int STATE_CH1_POS = 0;
  localparam int STATE_CH2_POS = 1;
  localparam int FAULT_SINGLE_POS = 1;
  localparam int FAULT_CH1_POS = 2;
  localparam int FAULT_CH2_POS = 3;
  localparam int NIBBLE_W = 4;
  // Byte lanes within an image word
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 8'h01;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 2'h0;
  localparam logic [SLOT_W-1:0] SLOT_ONE = 2'h1;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 2'h3;
  // Kinds of digital input module a slot can hold
  typedef enum logic [KIND_W-1:0] {
    KIND_NONE,
    KIND_1CH_DIAG,
    KIND_2CH,
    KIND_2CH_DIAG,
    KIND_4CH,
    KIND_8CH
  } slot_kind_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PACK,
    ST_FLUSH
  } pack_state_type;
endpackage : dig_image_pkg

// file: digital_slot_byte_former.sv
// Forms the image byte of one digital input module from its channels
`timescale 1ns/100ps
module digital_slot_byte_former
  import dig_image_pkg::*;
(
  input wire dig_image_pkg::slot_kind_type kind_i, // Module kind
  input wire logic [dig_image_pkg::CH_MAX-1:0] state_i, // Channel levels
  input wire logic [dig_image_pkg::CH_MAX-1:0] fault_i, // Channel faults
  output logic [dig_image_pkg::BYTE_W-1:0] byte_o // Packed image byte
);
  import dig_image_pkg::*;

  // Every path starts from zero so unused bits never leak
  always_comb begin
    byte_o = BYTE_ZERO;
    unique case (kind_i)
      KIND_NONE: begin
        byte_o = BYTE_ZERO;
      end
      KIND_1CH_DIAG: begin
        byte_o[STATE_CH1_POS] = state_i[0];
        byte_o[FAULT_SINGLE_POS] = fault_i[0];
      end
      KIND_2CH: begin
        byte_o[STATE_CH1_POS] = state_i[0];
        byte_o[STATE_CH2_POS] = state_i[1];
      end
      KIND_2CH_DIAG: begin
        byte_o[STATE_CH1_POS] = state_i[0];
        byte_o[STATE_CH2_POS] = state_i[1];
        byte_o[FAULT_CH1_POS] = fault_i[0];
        byte_o[FAULT_CH2_POS] = fault_i[1];
      end
      KIND_4CH: begin
        byte_o[NIBBLE_W-1:0] = state_i[NIBBLE_W-1:0];
      end
      KIND_8CH: begin
        byte_o = state_i;
      end
      // Codes past the last kind give a zero byte, as an empty slot does
      default: begin
        byte_o = BYTE_ZERO;
      end
    endcase
  end
endmodule : digital_slot_byte_former

// file: dig_module_chain.sv
// Model of the chain of digital input modules feeding the packer
`timescale 1ns/100ps
module dig_module_chain (
  input wire logic clk_i, // Bench clock
  input wire logic [11:0] kinds_i, // Fitted kind per slot
  input wire logic [31:0] levels_i, // Field levels per slot
  input wire logic [31:0] faults_i, // Field faults per slot
  output logic [11:0] slot_kind_o, // Kind per slot
  output logic [31:0] slot_state_o, // Channel levels
  output logic [31:0] slot_fault_o // Channel faults
);
  logic [7:0] junk_r = 8'h5a;
  logic [7:0] lmask;
  logic [7:0] fmask;
  // Lines a module lacks float, so they change every cycle
  // Plain always, since the variable also carries a start value
  always @(posedge clk_i) begin
    junk_r <= ~junk_r;
  end
  // Only the lines a module really has carry its field values
  always_comb begin
    slot_kind_o = kinds_i;
    for (int g = 0; g < 4; g++) begin
      case (kinds_i[3*g +: 3])
        3'h1: {lmask, fmask} = 16'h0101;
        3'h2: {lmask, fmask} = 16'h0300;
        3'h3: {lmask, fmask} = 16'h0303;
        3'h4: {lmask, fmask} = 16'h0f00;
        3'h5: {lmask, fmask} = 16'hff00;
        default: {lmask, fmask} = 16'h0000;
      endcase
      slot_state_o[8*g +: 8] = (levels_i[8*g +: 8] & lmask) | (junk_r & ~lmask);
      slot_fault_o[8*g +: 8] = (faults_i[8*g +: 8] & fmask) | (~junk_r & ~fmask);
    end
  end
endmodule : dig_module_chain

// file: digital_input_image_packer_test.sv
// Self-checking bench for the digital input image packer
`timescale 1ns/100ps
module digital_input_image_packer_test;
  typedef struct packed {
    logic [7:0] base;
    logic [11:0] kinds;
    logic [31:0] lv;
    logic [31:0] ft;
  } row_type;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scan_start = 1'b0;
  logic [7:0] analog_words = 8'h00;
  logic [11:0] kinds = 12'h000;
  logic [31:0] levels = 32'h0;
  logic [31:0] faults = 32'h0;
  logic [11:0] slot_kind;
  logic [31:0] slot_state;
  logic [31:0] slot_fault;
  logic img_wr_o;
  logic [7:0] img_addr_o;
  logic [15:0] img_data_o;
  logic busy_o;
  logic done_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Each kind appears, every layout but the 8-channel one in slot 0; odd counts and gaps included
  row_type rows [7] = '{
    '{8'h03, 12'h492, 32'hffffffff, 32'hffffffff},
    '{8'h00, 12'hb19, 32'h5a3c0201, 32'h00000303},
    '{8'h07, 12'h001, 32'h00000001, 32'h00000000},
    '{8'h10, 12'h7e8, 32'h02ffa500, 32'h01ffff00},
    '{8'hfe, 12'h182, 32'hffffff02, 32'hffffffff},
    '{8'h20, 12'h01c, 32'h000002a7, 32'h00000200},
    '{8'h30, 12'h003, 32'h00000001, 32'h00000002}};
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  dig_module_chain i_chain (.clk_i(core_clk_i), .kinds_i(kinds),
    .levels_i(levels), .faults_i(faults), .slot_kind_o(slot_kind),
    .slot_state_o(slot_state), .slot_fault_o(slot_fault));
  digital_input_image_packer i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .scan_start_i(scan_start), .analog_words_i(analog_words),
    .slot_kind_i(slot_kind), .slot_state_i(slot_state),
    .slot_fault_i(slot_fault), .img_wr_o(img_wr_o), .img_addr_o(img_addr_o),
    .img_data_o(img_data_o), .busy_o(busy_o), .done_o(done_o));
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Expected image byte worked out per kind; unused bits stay zero
  function automatic logic [7:0] exp_byte(input logic [2:0] k,
      input logic [7:0] l, input logic [7:0] f);
    case (k)
      3'h1: return {6'h00, f[0], l[0]};
      3'h2: return {6'h00, l[1:0]};
      3'h3: return {4'h0, f[1:0], l[1:0]};
      3'h4: return {4'h0, l[3:0]};
      3'h5: return l;
      default: return 8'h00;
    endcase
  endfunction : exp_byte
  // One scan; extra gives a second start while busy, which must be ignored
  task automatic run_scan(input row_type r, input bit extra);
    logic [7:0] q[$];
    int n;
    int nw;
    int dn;
    int odd;
    for (int g = 0; g < 4; g++) begin
      if (r.kinds[3*g +: 3] != 3'h0)
        q.push_back(exp_byte(r.kinds[3*g +: 3], r.lv[8*g +: 8], r.ft[8*g +: 8]));
    end
    odd = q.size() % 2;
    if (odd == 1) q.push_back(8'h00);
    @(negedge core_clk_i);
    {analog_words, kinds, levels, faults} = r;
    scan_start = 1'b1;
    n = 0;
    nw = 0;
    dn = 0;
    repeat (12) begin
      @(negedge core_clk_i);
      scan_start = extra && n == 1;
      @(posedge core_clk_i);
      #1;
      n++;
      if (n == 1) check("busy", 16'h0001, {15'h0, busy_o});
      if (img_wr_o === 1'b1 && 2 * nw + 1 < q.size()) begin
        check("addr", {8'h00, r.base + nw[7:0]}, {8'h00, img_addr_o});
        check("data", {q[2*nw+1], q[2*nw]}, img_data_o);
        nw++;
      end else if (img_wr_o === 1'b1) begin
        check("stray write", 16'h0000, 16'h0001);
      end
      if (done_o === 1'b1) begin
        dn = n;
        check("busy at done", 16'h0000, {15'h0, busy_o});
      end
    end
    check("words", q.size() / 2, nw);
    // The last slot is packed four edges after the start; a pad word adds one
    check("done cycle", 4 + odd, dn);
  endtask : run_scan
  // Bounded run: a hang ends in the same closing report
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    #1;
    check("reset outputs", 16'h0000, {5'h0, img_wr_o, busy_o, done_o, img_addr_o});
    check("reset data", 16'h0000, img_data_o);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      run_scan(rows[i], 1'b0);
      $display("row %0d finished", i);
    end
    run_scan(rows[0], 1'b1);
    $display("start while busy finished");
    // Reset in mid-scan must clear everything at once
    @(negedge core_clk_i);
    scan_start = 1'b1;
    @(negedge core_clk_i);
    scan_start = 1'b0;
    @(negedge core_clk_i);
    rst_i = 1'b1;
    #1;
    check("abort outputs", 16'h0000, {5'h0, img_wr_o, busy_o, done_o, img_addr_o});
    check("abort data", 16'h0000, img_data_o);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    run_scan(rows[1], 1'b0);
    $display("reset in mid-scan finished");
    print_verdict();
  end
endmodule : digital_input_image_packer_test
